// ### src/rpa_map.svh
`ifndef RPA_MAP_SVH
`define RPA_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define RPA_ADDR_PATTERN_CTRL 8'h11
`define RPA_ADDR_AUDIO_A      8'h2a
`define RPA_ADDR_AUDIO_B      8'h2b
`define RPA_ADDR_CMD_BASE     8'h30
`define RPA_CMD_COUNT         8
// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define RPA_AUDIO_A_RESET     8'h03
`define RPA_AUDIO_B_RESET     8'h00
`define RPA_AUDIO_B_MASK      8'h1f
`define RPA_PATTERN_MASK      8'h07
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RPA_GAIN_HI           7
`define RPA_GAIN_LO           5
`define RPA_FILTER_BIT        4
`define RPA_AGC_BIT           3
`define RPA_FOLLOW_BIT        2
`define RPA_AVG_BIT           4
`define RPA_RUN_BIT           2
`define RPA_REPEAT_BIT        1
`define RPA_CURVE_BIT         0
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RPA_CLK_HZ            10000000
`define RPA_STEP_MS_0         197
`define RPA_STEP_MS_1         393
`define RPA_STEP_MS_2         590
`define RPA_STEP_MS_3         786
`define RPA_STEP_MS_4         983
`define RPA_STEP_MS_5         1180
`define RPA_STEP_MS_6         1376
`define RPA_STEP_MS_7         1573
`define RPA_STEP_MS_8         1769
`define RPA_STEP_MS_9         1966
`define RPA_STEP_MS_10        2163
`define RPA_STEP_MS_11        2359
`define RPA_STEP_MS_12        2556
`define RPA_STEP_MS_13        2753
`define RPA_STEP_MS_14        2949
`define RPA_STEP_MS_15        3146
`define RPA_FADE_MS_1         55
`define RPA_FADE_MS_2         110
`define RPA_FADE_MS_3         221
`define RPA_FADE_MS_4         442
`define RPA_FADE_MS_5         885
`define RPA_FADE_MS_6         1770
`define RPA_FADE_MS_7         3539

`endif

// ### src/rpa_pkg.sv
package rpa_pkg;

  typedef enum logic [1:0] {
    RPA_IDLE = 2'b00,
    RPA_FADE = 2'b01,
    RPA_HOLD = 2'b10,
    RPA_DONE = 2'b11
  } rpa_state_type;

  typedef logic [6:0]  rpa_pct_type;
  typedef logic [11:0] rpa_ms_type;

  // 3-bit level to percent of maximum current
  function automatic rpa_pct_type rpa_level_pct(input logic [2:0] code, input logic curve);
    rpa_pct_type p;
    p = 7'h00;
    case ({curve, code})
      4'h1:    p = 7'h07;
      4'h2:    p = 7'h0e;
      4'h3:    p = 7'h15;
      4'h4:    p = 7'h20;
      4'h5:    p = 7'h2e;
      4'h6:    p = 7'h47;
      4'h7:    p = 7'h64;
      4'h9:    p = 7'h01;
      4'ha:    p = 7'h02;
      4'hb:    p = 7'h04;
      4'hc:    p = 7'h0a;
      4'hd:    p = 7'h15;
      4'he:    p = 7'h2e;
      4'hf:    p = 7'h64;
      default: p = 7'h00;
    endcase
    return p;
  endfunction : rpa_level_pct

endpackage : rpa_pkg

// ### src/rpa_fade.sv
module rpa_fade
  import rpa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clear,
  input  wire logic        load,
  input  wire logic        fading,
  input  wire rpa_pct_type target,
  input  wire rpa_ms_type  fade_ms,
  input  wire rpa_ms_type  elapsed_ms,
  output rpa_pct_type      pct
);

  rpa_pct_type pct_r, pct_nxt;
  rpa_pct_type from_r, from_nxt;
  logic [18:0] span;
  rpa_pct_type delta;

  // ----------------------------------------------------------------------------
  // linear ramp from the latched start level
  // ----------------------------------------------------------------------------
  always_comb begin
    from_nxt = from_r;
    pct_nxt  = pct_r;
    span     = 19'h00000;
    delta    = 7'h00;
    if (clear) begin
      from_nxt = 7'h00;
      pct_nxt  = 7'h00;
    end else if (load) begin
      from_nxt = pct_r;
    end else if (fading) begin
      if (elapsed_ms >= fade_ms) begin
        pct_nxt = target;
      end else if (target >= from_r) begin
        span    = 19'((target - from_r) * elapsed_ms);
        delta   = 7'(span / fade_ms);
        pct_nxt = 7'(from_r + delta);
      end else begin
        span    = 19'((from_r - target) * elapsed_ms);
        delta   = 7'(span / fade_ms);
        pct_nxt = 7'(from_r - delta);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pct_r  <= 7'h00;
      from_r <= 7'h00;
    end else begin
      pct_r  <= pct_nxt;
      from_r <= from_nxt;
    end
  end

  assign pct = pct_r;

endmodule : rpa_fade

// ### src/rpa_ctrl.sv
`include "rpa_map.svh"

module rpa_ctrl
  import rpa_pkg::*;
#(
  parameter int CYC_PER_MS = `RPA_CLK_HZ / 1000
)(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [2:0] gain_sel,
  output logic            filter_freq_mode,
  output logic            auto_gain_on,
  output logic            audio_follow_on,
  output logic      [1:0] adc_source,
  output logic            averaging_on,
  output logic      [1:0] filter_ctrl,
  output logic      [1:0] response_rate,
  output rpa_pct_type     red_pct,
  output rpa_pct_type     green_pct,
  output rpa_pct_type     blue_pct,
  output logic            seq_busy,
  output logic      [2:0] cmd_index
);

  // ----------------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------------
  logic [7:0] audio_a_r, audio_a_nxt;
  logic [7:0] audio_b_r, audio_b_nxt;
  logic [7:0] pattern_r, pattern_nxt;
  logic [7:0] cmd_r   [2*`RPA_CMD_COUNT];
  logic [7:0] cmd_nxt [2*`RPA_CMD_COUNT];
  logic [7:0] rdata_r, rdata_nxt;
  logic       cmd_hit;
  logic [3:0] cmd_sel;

  assign cmd_hit = (reg_addr >= `RPA_ADDR_CMD_BASE) &&
                   (reg_addr < 8'(`RPA_ADDR_CMD_BASE + 2 * `RPA_CMD_COUNT));
  assign cmd_sel = 4'(reg_addr - `RPA_ADDR_CMD_BASE);

  always_comb begin
    audio_a_nxt = audio_a_r;
    audio_b_nxt = audio_b_r;
    pattern_nxt = pattern_r;
    cmd_nxt     = cmd_r;
    rdata_nxt   = rdata_r;
    if (reg_wr) begin
      if (reg_addr == `RPA_ADDR_AUDIO_A) begin
        audio_a_nxt = reg_wdata;
      end else if (reg_addr == `RPA_ADDR_AUDIO_B) begin
        audio_b_nxt = reg_wdata & `RPA_AUDIO_B_MASK;
      end else if (reg_addr == `RPA_ADDR_PATTERN_CTRL) begin
        pattern_nxt = reg_wdata & `RPA_PATTERN_MASK;
      end else if (cmd_hit) begin
        cmd_nxt[cmd_sel] = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == `RPA_ADDR_AUDIO_A) begin
        rdata_nxt = audio_a_r;
      end else if (reg_addr == `RPA_ADDR_AUDIO_B) begin
        rdata_nxt = audio_b_r;
      end else if (reg_addr == `RPA_ADDR_PATTERN_CTRL) begin
        rdata_nxt = pattern_r;
      end else if (cmd_hit) begin
        rdata_nxt = cmd_r[cmd_sel];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      audio_a_r <= `RPA_AUDIO_A_RESET;
      audio_b_r <= `RPA_AUDIO_B_RESET;
      pattern_r <= 8'h00;
      rdata_r   <= 8'h00;
      for (int i = 0; i < 2 * `RPA_CMD_COUNT; i++) begin
        cmd_r[i] <= 8'h00;
      end
    end else begin
      audio_a_r <= audio_a_nxt;
      audio_b_r <= audio_b_nxt;
      pattern_r <= pattern_nxt;
      rdata_r   <= rdata_nxt;
      cmd_r     <= cmd_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // audio and converter controls
  // ----------------------------------------------------------------------------
  assign reg_rdata        = rdata_r;
  assign gain_sel         = audio_a_r[`RPA_GAIN_HI:`RPA_GAIN_LO];
  assign filter_freq_mode = audio_a_r[`RPA_FILTER_BIT];
  assign auto_gain_on     = audio_a_r[`RPA_AGC_BIT];
  assign audio_follow_on  = audio_a_r[`RPA_FOLLOW_BIT];
  assign adc_source       = audio_a_r[1:0];
  assign averaging_on     = audio_b_r[`RPA_AVG_BIT];
  assign filter_ctrl      = audio_b_r[3:2];
  assign response_rate    = audio_b_r[1:0];

  // ----------------------------------------------------------------------------
  // millisecond time base
  // ----------------------------------------------------------------------------
  logic [$clog2(CYC_PER_MS)-1:0] pre_r, pre_nxt;
  logic                          ms_tick;

  assign ms_tick = (pre_r == ($clog2(CYC_PER_MS))'(CYC_PER_MS - 1));

  always_comb begin
    pre_nxt = ms_tick ? '0 : ($clog2(CYC_PER_MS))'(pre_r + 1'b1);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // pattern sequencer
  // ----------------------------------------------------------------------------
  rpa_state_type state_r, state_nxt;
  logic [2:0]    idx_r, idx_nxt;
  rpa_ms_type    elapsed_r, elapsed_nxt;
  rpa_ms_type    fade_ms, step_ms;
  logic [3:0]    step_code;
  logic [7:0]    word_a, word_b;
  logic          run, load, clear;
  logic          busy_r, busy_nxt;

  assign run       = pattern_r[`RPA_RUN_BIT];
  assign word_a    = cmd_r[{idx_r, 1'b0}];
  assign word_b    = cmd_r[{idx_r, 1'b1}];
  assign step_code = {word_a[1:0], word_b[7:6]};
  // step time per code, uneven rounding kept per entry
  always_comb begin
    case (step_code)
      4'h0:    step_ms = 12'(`RPA_STEP_MS_0);
      4'h1:    step_ms = 12'(`RPA_STEP_MS_1);
      4'h2:    step_ms = 12'(`RPA_STEP_MS_2);
      4'h3:    step_ms = 12'(`RPA_STEP_MS_3);
      4'h4:    step_ms = 12'(`RPA_STEP_MS_4);
      4'h5:    step_ms = 12'(`RPA_STEP_MS_5);
      4'h6:    step_ms = 12'(`RPA_STEP_MS_6);
      4'h7:    step_ms = 12'(`RPA_STEP_MS_7);
      4'h8:    step_ms = 12'(`RPA_STEP_MS_8);
      4'h9:    step_ms = 12'(`RPA_STEP_MS_9);
      4'ha:    step_ms = 12'(`RPA_STEP_MS_10);
      4'hb:    step_ms = 12'(`RPA_STEP_MS_11);
      4'hc:    step_ms = 12'(`RPA_STEP_MS_12);
      4'hd:    step_ms = 12'(`RPA_STEP_MS_13);
      4'he:    step_ms = 12'(`RPA_STEP_MS_14);
      default: step_ms = 12'(`RPA_STEP_MS_15);
    endcase
  end

  always_comb begin
    case (word_b[2:0])
      3'h1:    fade_ms = 12'(`RPA_FADE_MS_1);
      3'h2:    fade_ms = 12'(`RPA_FADE_MS_2);
      3'h3:    fade_ms = 12'(`RPA_FADE_MS_3);
      3'h4:    fade_ms = 12'(`RPA_FADE_MS_4);
      3'h5:    fade_ms = 12'(`RPA_FADE_MS_5);
      3'h6:    fade_ms = 12'(`RPA_FADE_MS_6);
      3'h7:    fade_ms = 12'(`RPA_FADE_MS_7);
      default: fade_ms = 12'h000;
    endcase
  end

  always_comb begin
    state_nxt   = state_r;
    idx_nxt     = idx_r;
    elapsed_nxt = ms_tick ? 12'(elapsed_r + 1'b1) : elapsed_r;
    load        = 1'b0;
    clear       = 1'b0;
    case (state_r)
      RPA_IDLE: begin
        elapsed_nxt = 12'h000;
        if (run) begin
          state_nxt = RPA_FADE;
          idx_nxt   = 3'h0;
          load      = 1'b1;
        end
      end
      RPA_FADE: begin
        if (elapsed_r >= fade_ms) begin
          state_nxt   = RPA_HOLD;
          elapsed_nxt = 12'h000;
        end
      end
      RPA_HOLD: begin
        if (elapsed_r >= step_ms) begin
          elapsed_nxt = 12'h000;
          if (idx_r != 3'(`RPA_CMD_COUNT - 1)) begin
            state_nxt = RPA_FADE;
            idx_nxt   = 3'(idx_r + 1'b1);
            load      = 1'b1;
          end else if (pattern_r[`RPA_REPEAT_BIT]) begin
            state_nxt = RPA_FADE;
            idx_nxt   = 3'h0;
            load      = 1'b1;
          end else begin
            state_nxt = RPA_DONE;
          end
        end
      end
      RPA_DONE: begin
        elapsed_nxt = 12'h000;
      end
      default: begin
        state_nxt = RPA_IDLE;
      end
    endcase
    if (!run && state_r != RPA_IDLE) begin
      state_nxt   = RPA_IDLE;
      idx_nxt     = 3'h0;
      elapsed_nxt = 12'h000;
      clear       = 1'b1;
    end
    busy_nxt    = (state_nxt == RPA_FADE) || (state_nxt == RPA_HOLD);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= RPA_IDLE;
      idx_r     <= 3'h0;
      elapsed_r <= 12'h000;
      busy_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      idx_r     <= idx_nxt;
      elapsed_r <= elapsed_nxt;
      busy_r    <= busy_nxt;
    end
  end

  assign seq_busy  = busy_r;
  assign cmd_index = idx_r;

  // ----------------------------------------------------------------------------
  // colour channels
  // ----------------------------------------------------------------------------
  logic [2:0]  lvl [3];
  rpa_pct_type pct [3];

  assign lvl[0] = word_a[7:5];
  assign lvl[1] = word_a[4:2];
  assign lvl[2] = word_b[5:3];

  for (genvar c = 0; c < 3; c++) begin : g_chan
    rpa_fade u_fade (
      .clk        (clk),
      .arst_n     (arst_n),
      .clear      (clear),
      .load       (load),
      .fading     (state_r == RPA_FADE),
      .target     (rpa_level_pct(lvl[c], pattern_r[`RPA_CURVE_BIT])),
      .fade_ms    (fade_ms),
      .elapsed_ms (elapsed_r),
      .pct        (pct[c])
    );
  end

  assign red_pct   = pct[0];
  assign green_pct = pct[1];
  assign blue_pct  = pct[2];

endmodule : rpa_ctrl

// ### sim/rpa_ctrl_checker.sv
module rpa_ctrl_checker
  import rpa_pkg::*;
#(
  parameter int CYC_PER_MS = 10
)(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [2:0]  gain_sel,
  input wire logic        filter_freq_mode,
  input wire logic        auto_gain_on,
  input wire logic        audio_follow_on,
  input wire logic [1:0]  adc_source,
  input wire logic        averaging_on,
  input wire logic [1:0]  filter_ctrl,
  input wire logic [1:0]  response_rate,
  input wire rpa_pct_type red_pct,
  input wire rpa_pct_type green_pct,
  input wire rpa_pct_type blue_pct,
  input wire logic        seq_busy,
  input wire logic [2:0]  cmd_index
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------
  // shadow of the run bit
  // ---------------------------------------------
  logic run_r;
  logic run_nxt;
  always_comb begin
    run_nxt = run_r;
    if (reg_wr && reg_addr == 8'h11) begin
      run_nxt = reg_wdata[2];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
    end
  end
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_gain;
    reg_wr && reg_addr == 8'h2a |=> gain_sel == $past(reg_wdata[7:5]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain code not taken");
  property p_flags;
    reg_wr && reg_addr == 8'h2a |=>
      {filter_freq_mode, auto_gain_on, audio_follow_on, adc_source} == $past(reg_wdata[4:0]);
  endproperty
  a_flags: assert property (p_flags) else $error("audio control a fields wrong");
  property p_gain_hold;
    !(reg_wr && reg_addr == 8'h2a) |=> $stable(gain_sel) && $stable(adc_source);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("audio control a changed unasked");
  property p_ctrl_b;
    reg_wr && reg_addr == 8'h2b |=> {averaging_on, filter_ctrl, response_rate} == $past(reg_wdata[4:0]);
  endproperty
  a_ctrl_b: assert property (p_ctrl_b) else $error("audio control b fields wrong");
  property p_read_b;
    reg_rd && reg_addr == 8'h2b |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_read_b: assert property (p_read_b) else $error("reserved bits not zero");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_start;
    reg_wr && reg_addr == 8'h11 && reg_wdata[2] && !run_r |=> ##1 seq_busy && cmd_index == 3'h0;
  endproperty
  a_start: assert property (p_start) else $error("pattern did not start at first command");
  property p_stop;
    reg_wr && reg_addr == 8'h11 && !reg_wdata[2] |=> ##1
      !seq_busy && red_pct == 7'h00 && green_pct == 7'h00 && blue_pct == 7'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("pattern not stopped");
  property p_order;
    cmd_index != $past(cmd_index) |-> cmd_index == 3'($past(cmd_index) + 3'h1) || cmd_index == 3'h0;
  endproperty
  a_order: assert property (p_order) else $error("command order broken");
endmodule : rpa_ctrl_checker

bind rpa_ctrl rpa_ctrl_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gain_sel(gain_sel), .filter_freq_mode(filter_freq_mode),
  .auto_gain_on(auto_gain_on), .audio_follow_on(audio_follow_on), .adc_source(adc_source),
  .averaging_on(averaging_on), .filter_ctrl(filter_ctrl), .response_rate(response_rate),
  .red_pct(red_pct), .green_pct(green_pct), .blue_pct(blue_pct), .seq_busy(seq_busy),
  .cmd_index(cmd_index)
);

// ### sim/rpa_led_model.sv
module rpa_led_model
  import rpa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire rpa_pct_type red_pct,
  input  wire rpa_pct_type green_pct,
  input  wire rpa_pct_type blue_pct,
  output logic             over_range
);
  timeunit 1ns;
  timeprecision 1ns;
  logic over_nxt;
  // drivers cannot sink more than full scale
  always_comb begin
    over_nxt = over_range | (red_pct > 7'h64) | (green_pct > 7'h64) | (blue_pct > 7'h64);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      over_range <= 1'b0;
    end else begin
      over_range <= over_nxt;
    end
  end
endmodule : rpa_led_model

// ### sim/rpa_ctrl_bench.sv
module rpa_ctrl_bench
  import rpa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPM = 10;
  logic clk, arst_n, reg_wr, reg_rd, filter_freq_mode, auto_gain_on, audio_follow_on;
  logic averaging_on, seq_busy, over_range;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] gain_sel, cmd_index;
  logic [1:0] adc_source, filter_ctrl, response_rate;
  rpa_pct_type red_pct, green_pct, blue_pct;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  rpa_pct_type lut [2][8] = '{'{7'h00, 7'h07, 7'h0e, 7'h15, 7'h20, 7'h2e, 7'h47, 7'h64},
                              '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0a, 7'h15, 7'h2e, 7'h64}};
  localparam int fade_tbl [8] = '{0, 55, 110, 221, 442, 885, 1770, 3539};
  localparam int step_tbl [16] = '{197, 393, 590, 786, 983, 1180, 1376, 1573,
                                   1769, 1966, 2163, 2359, 2556, 2753, 2949, 3146};
  rpa_ctrl #(.CYC_PER_MS(CPM)) dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gain_sel(gain_sel),
    .filter_freq_mode(filter_freq_mode), .auto_gain_on(auto_gain_on), .audio_follow_on(audio_follow_on),
    .adc_source(adc_source), .averaging_on(averaging_on), .filter_ctrl(filter_ctrl),
    .response_rate(response_rate), .red_pct(red_pct), .green_pct(green_pct), .blue_pct(blue_pct),
    .seq_busy(seq_busy), .cmd_index(cmd_index));
  rpa_led_model u_led (.clk(clk), .arst_n(arst_n), .red_pct(red_pct), .green_pct(green_pct),
    .blue_pct(blue_pct), .over_range(over_range));
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  task automatic summarize;
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      summarize;
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg", 16'(reg_rdata), 16'(exp));
  endtask : rchk
  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  task automatic t_regs;
    logic [7:0] v;
    rchk(8'h2a, 8'h03);
    rchk(8'h2b, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = {3'(i), 3'(i) ^ 3'h3, 2'(i)};
      wr(8'h2a, v);
      rchk(8'h2a, v);
      chk("ctla", 16'({gain_sel, filter_freq_mode, auto_gain_on, audio_follow_on, adc_source}), 16'(v));
    end
    for (int i = 0; i < 4; i++) begin
      v = {3'h7, 1'(i), 2'(i), 2'(i)};
      wr(8'h2b, v);
      rchk(8'h2b, v & 8'h1f);
      chk("ctlb", 16'({averaging_on, filter_ctrl, response_rate}), 16'(v[4:0]));
    end
    wr(8'h20, 8'hff);
    rchk(8'h20, 8'h00);
    wr(8'h11, 8'hf8);
    rchk(8'h11, 8'h00);
    for (int i = 0; i < 16; i++) wr(8'(8'h30 + i), 8'(8'ha5 ^ (i * 17)));
    for (int i = 0; i < 16; i++) rchk(8'(8'h30 + i), 8'(8'ha5 ^ (i * 17)));
  endtask : t_regs
  task automatic t_seq(input logic curve, input logic rep, input logic [3:0] sc);
    int cyc, exp;
    logic [2:0] idx;
    rpa_pct_type rr, gg, bb;
    for (int i = 0; i < 8; i++) begin
      wr(8'(8'h30 + 2 * i), {3'(7 + 5 * i), 3'(i), sc[3:2]});
      wr(8'(8'h31 + 2 * i), {sc[1:0], 3'(3 * i + 1), (i == 1) ? 3'h1 : 3'h0});
    end
    wr(8'h11, {5'h00, 1'b1, rep, curve});
    repeat (2) @(posedge clk);
    #1 chk("start", 16'({seq_busy, cmd_index}), 16'h8);
    for (int k = 0; k < 8; k++) begin
      idx = cmd_index;
      cyc = 0;
      if (k == 1) chk("ramp", 16'(red_pct > 7'h32), 16'h1);
      while (cmd_index === idx && seq_busy === 1'b1 && cyc < 40000) begin
        rr = red_pct; gg = green_pct; bb = blue_pct;
        @(posedge clk);
        #1 cyc++;
      end
      chk("idx", 16'(idx), 16'(k));
      chk("rgb", {rr, gg, 2'b00}, {lut[curve][3'(7 + 5 * k)], lut[curve][3'(k)], 2'b00});
      chk("blue", 16'(bb), 16'(lut[curve][3'(3 * k + 1)]));
      exp = (step_tbl[sc] + ((k == 1) ? fade_tbl[1] : 0)) * CPM;
      if (k > 0) chk("dur", 16'(cyc >= exp - CPM - 2 && cyc <= exp + CPM + 2), 16'h1);
    end
    chk("end", 16'({seq_busy, cmd_index == 3'h0}), rep ? 16'h3 : 16'h0);
    if (!rep) chk("held", 16'(red_pct), 16'(lut[curve][2]));
    wr(8'h11, {7'h00, curve});
    repeat (2) @(posedge clk);
    #1 chk("off", 16'({red_pct, green_pct, seq_busy}), 16'h0);
  endtask : t_seq
  // ramp level 50 ms into fade codes 1 to 7, full red from zero
  task automatic t_fade;
    for (int c = 1; c < 8; c++) begin
      wr(8'h30, 8'he0);
      wr(8'h31, 8'(c));
      wr(8'h11, 8'h04);
      repeat (50 * CPM + 2) @(posedge clk);
      #1 chk("fade", 16'(red_pct), 16'(100 * 50 / fade_tbl[c]));
      wr(8'h11, 8'h00);
    end
  endtask : t_fade
  initial begin
    arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_seq(1'b0, 1'b0, 4'h0);
    t_seq(1'b1, 1'b1, 4'h1);
    t_fade;
    chk("drive", 16'(over_range), 16'h0);
    summarize;
  end
endmodule : rpa_ctrl_bench
